// *** hdl/or_move_instruction_exec.sv ***
// Behaviour
// - The literal OR instruction ORs the accumulator with an 8-bit literal, writes the accumulator and sets zero.
// - The register OR instruction ORs the accumulator with file register 0..127 and sets zero from the result.
// - With selector 0 the register OR result goes to the accumulator and the file register stays unchanged.
// - With selector 1 the register OR result goes back to the addressed file register.
// - The move instruction reads file register 0..127 and, with selector 0, puts its value in the accumulator.
// - The move instruction with selector 1 writes the value back into the same file register.
// - The move instruction sets zero from the moved value even when it writes back to itself.

`include "or_move_map.svh"

module or_move_instruction_exec
#(
	parameter int depth = `FILE_DEPTH
)
(
	// Clock and reset
	input  wire logic                       clock,
	input  wire logic                       resetn,
	// Decoded instruction, one per cycle
	input  wire or_move_pkg::instr_t        instr,
	// Results
	output logic [`DATA_W-1:0]              acc,
	output logic [`DATA_W-1:0]              status,
	output or_move_pkg::file_wr_t           file_wr
);
	import or_move_pkg::*;

	// The address field is 7 bits wide, so a larger depth leaves cells unreachable and a smaller one leaves addresses with no cell
	if (depth != `FILE_DEPTH)
		$error("depth must match the 7-bit file address space");

	// ----------------------------------------
	// File registers
	// ----------------------------------------
	logic [`DATA_W-1:0] file_mem [depth];
	logic [`DATA_W-1:0] acc_reg;
	logic [`DATA_W-1:0] acc_next;
	logic [`DATA_W-1:0] status_reg;
	logic [`DATA_W-1:0] status_next;
	file_wr_t           file_wr_reg;
	file_wr_t           file_wr_next;
	logic [`DATA_W-1:0] operand;

	// Only the zero bit moves; every other status bit passes through untouched
	function automatic logic [`DATA_W-1:0] set_zero(input logic [`DATA_W-1:0] st,
		input logic [`DATA_W-1:0] res);
		logic [`DATA_W-1:0] s;
		s = st;
		s[`ZERO_BIT] = (res == `ZERO_BYTE);
		return s;
	endfunction

	// Read is combinational so the whole op fits in one cycle
	assign operand = file_mem[instr.addr];

	// ----------------------------------------
	// Execute
	// ----------------------------------------
	always_comb
	begin
		acc_next     = acc_reg;
		status_next  = status_reg;
		file_wr_next = '0;
		case (instr.op)
			or_literal_into_acc:
			begin
				acc_next    = acc_reg | instr.literal;
				status_next = set_zero(status_reg, acc_reg | instr.literal);
			end
			or_acc_with_file:
			begin
				status_next = set_zero(status_reg, acc_reg | operand);
				if (instr.dest_file)
				begin
					file_wr_next.write = 1'b1;
					file_wr_next.addr  = instr.addr;
					file_wr_next.data  = acc_reg | operand;
				end
				else
					acc_next = acc_reg | operand;
			end
			move_file_to_dest:
			begin
				status_next = set_zero(status_reg, operand);
				if (instr.dest_file)
				begin
					file_wr_next.write = 1'b1;
					file_wr_next.addr  = instr.addr;
					file_wr_next.data  = operand;
				end
				else
					acc_next = operand;
			end
			default:
			begin
				acc_next = acc_reg;
			end
		endcase
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			acc_reg     <= `ACC_RESET;
			status_reg  <= `STATUS_RESET;
			file_wr_reg <= '0;
		end
		else
		begin
			acc_reg     <= acc_next;
			status_reg  <= status_next;
			file_wr_reg <= file_wr_next;
		end
	end

	// Storage has no reset; contents are undefined until written
	// Written from the next value so a back-to-back read sees the new byte
	always_ff @(posedge clock)
	begin
		if (file_wr_next.write)
			file_mem[file_wr_next.addr] <= file_wr_next.data;
	end

	assign acc     = acc_reg;
	assign status  = status_reg;
	assign file_wr = file_wr_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Unwritten storage reads unknown, so checks that read it need loaded cells
	sequence lit_op_s;
		instr.op == or_literal_into_acc;
	endsequence

	sequence file_or_s;
		instr.op == or_acc_with_file;
	endsequence

	sequence move_op_s;
		instr.op == move_file_to_dest;
	endsequence

	sequence idle_op_s;
		instr.op == op_none;
	endsequence

	lit_or_acc_a: assert property (@(posedge clock) disable iff (!resetn)
		lit_op_s |=> acc_reg == ($past(acc_reg) | $past(instr.literal)))
		else $error("literal OR result wrong");

	reg_or_zero_a: assert property (@(posedge clock) disable iff (!resetn)
		instr.op == or_acc_with_file |=> status_reg[`ZERO_BIT] == (($past(acc_reg) | $past(operand)) == `ZERO_BYTE))
		else $error("register OR zero flag wrong");

	or_to_acc_a: assert property (@(posedge clock) disable iff (!resetn)
		instr.op == or_acc_with_file && !instr.dest_file |=> !file_wr_reg.write
		&& acc_reg == ($past(acc_reg) | $past(operand)))
		else $error("register OR to accumulator wrong");

	or_to_file_a: assert property (@(posedge clock) disable iff (!resetn)
		instr.op == or_acc_with_file && instr.dest_file |=> file_wr_reg.write && acc_reg == $past(acc_reg)
		&& file_wr_reg.data == ($past(acc_reg) | $past(operand)))
		else $error("register OR to file wrong");

	move_to_acc_a: assert property (@(posedge clock) disable iff (!resetn)
		instr.op == move_file_to_dest && !instr.dest_file |=> acc_reg == $past(operand) && !file_wr_reg.write)
		else $error("move to accumulator wrong");

	move_to_file_a: assert property (@(posedge clock) disable iff (!resetn)
		instr.op == move_file_to_dest && instr.dest_file |=> file_wr_reg.write && file_wr_reg.addr == $past(instr.addr))
		else $error("move write-back wrong");

	move_zero_a: assert property (@(posedge clock) disable iff (!resetn)
		instr.op == move_file_to_dest |=> status_reg[`ZERO_BIT] == ($past(operand) == `ZERO_BYTE))
		else $error("move zero flag wrong");

	other_flags_a: assert property (@(posedge clock) disable iff (!resetn)
		1'b1 |=> (status_reg & ~`ZERO_MASK) == ($past(status_reg) & ~`ZERO_MASK))
		else $error("non-zero status bit changed");

	lit_zero_a: assert property (@(posedge clock) disable iff (!resetn)
		lit_op_s |=> status_reg[`ZERO_BIT] == (($past(acc_reg) | $past(instr.literal)) == `ZERO_BYTE))
		else $error("literal OR zero flag wrong");

	lit_no_write_a: assert property (@(posedge clock) disable iff (!resetn)
		lit_op_s |=> !file_wr_reg.write)
		else $error("literal OR wrote a file register");

	or_dest_sel_a: assert property (@(posedge clock) disable iff (!resetn)
		file_or_s |=> file_wr_reg.write == $past(instr.dest_file))
		else $error("register OR selector not followed");

	or_file_addr_a: assert property (@(posedge clock) disable iff (!resetn)
		instr.op == or_acc_with_file && instr.dest_file |=> file_wr_reg.addr == $past(instr.addr))
		else $error("register OR write address wrong");

	move_data_a: assert property (@(posedge clock) disable iff (!resetn)
		move_op_s |=> (file_wr_reg.write ? file_wr_reg.data : acc_reg) == $past(operand))
		else $error("moved value wrong");

	move_acc_keep_a: assert property (@(posedge clock) disable iff (!resetn)
		instr.op == move_file_to_dest && instr.dest_file |=> acc_reg == $past(acc_reg))
		else $error("move write-back touched accumulator");

	idle_hold_a: assert property (@(posedge clock) disable iff (!resetn)
		idle_op_s |=> !file_wr_reg.write && $stable(acc_reg) && $stable(status_reg))
		else $error("idle slot changed state");

	// Storage and the write record must agree, or a later read sees stale data
	write_lands_a: assert property (@(posedge clock) disable iff (!resetn)
		file_wr_reg.write |-> file_mem[file_wr_reg.addr] === file_wr_reg.data)
		else $error("file write did not land");

	fresh_read_a: assert property (@(posedge clock) disable iff (!resetn)
		file_wr_reg.write && instr.op == move_file_to_dest && instr.addr == file_wr_reg.addr
		|-> operand === file_wr_reg.data)
		else $error("back-to-back read saw stale byte");

endmodule

// *** hdl/or_move_map.svh ***
`ifndef OR_MOVE_MAP_SVH
`define OR_MOVE_MAP_SVH

// Field widths and reset values
`define DATA_W        8
`define FILE_ADDR_W   7
`define FILE_DEPTH    128
`define ACC_RESET     8'h00
`define STATUS_RESET  8'h00
`define ZERO_BIT      2
`define ZERO_BYTE     8'h00
`define ZERO_MASK     8'h04

`endif

// *** hdl/or_move_pkg.sv ***
`include "or_move_map.svh"

package or_move_pkg;

	typedef enum logic [1:0]
	{
		op_none,
		or_literal_into_acc,
		or_acc_with_file,
		move_file_to_dest
	} op_t;

	typedef struct packed
	{
		op_t                         op;
		logic [`DATA_W-1:0]          literal;
		logic [`FILE_ADDR_W-1:0]     addr;
		logic                        dest_file;
	} instr_t;

	typedef struct packed
	{
		logic                        write;
		logic [`FILE_ADDR_W-1:0]     addr;
		logic [`DATA_W-1:0]          data;
	} file_wr_t;

endpackage

// *** tb/tb.sv ***
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import or_move_pkg::*;

	logic      clock;
	logic      resetn;
	instr_t    instr;
	logic [7:0] acc;
	logic [7:0] status;
	file_wr_t  file_wr;
	int        n_errors;
	int        n_checks;

	or_move_instruction_exec #(.depth(128)) uut (.clock(clock), .resetn(resetn), .instr(instr),
		.acc(acc), .status(status), .file_wr(file_wr));

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	// File storage survives reset, so a second reset keeps earlier writes
	task do_reset;
		@(posedge clock);
		resetn <= 1'b0;
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		#1;
		chk(acc, 8'h00);
		chk(status, 8'h00);
		chk(file_wr, 16'h0000);
	endtask

	task run(input op_t op, input logic [7:0] lit, input logic [6:0] addr, input logic dest);
		@(posedge clock);
		instr <= '{op, lit, addr, dest};
		@(posedge clock);
		instr <= '{op_none, 8'h00, 7'h00, 1'b0};
		#1;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_literal;
		run(or_literal_into_acc, 8'h00, 7'h00, 1'b0);
		chk(acc, 8'h00);
		chk(status, 8'h04);
		run(or_literal_into_acc, 8'h5A, 7'h00, 1'b0);
		chk(acc, 8'h5A);
		chk(status, 8'h00);
		chk(file_wr.write, 1'b0);
		run(or_literal_into_acc, 8'hA5, 7'h00, 1'b0);
		chk(acc, 8'hFF);
	endtask

	// Unwritten file bytes are unknown, so only all-ones values are exact
	task t_or_file;
		run(or_acc_with_file, 8'h00, 7'h7F, 1'b1);
		chk(file_wr, {1'b1, 7'h7F, 8'hFF});
		chk(acc, 8'hFF);
		run(or_acc_with_file, 8'h00, 7'h00, 1'b1);
		chk(file_wr, {1'b1, 7'h00, 8'hFF});
		run(or_acc_with_file, 8'h00, 7'h7F, 1'b0);
		chk(acc, 8'hFF);
		chk(file_wr.write, 1'b0);
		chk(status, 8'h00);
	endtask

	// The write pulse stands one cycle; an idle slot after it changes nothing
	task t_idle;
		run(or_acc_with_file, 8'h00, 7'h01, 1'b1);
		chk(file_wr, {1'b1, 7'h01, 8'hFF});
		@(posedge clock);
		#1;
		chk(file_wr, 16'h0000);
		chk(acc, 8'hFF);
		chk(status, 8'h00);
	endtask

	// Cell 02 is unwritten, so a stale read would leave the accumulator unknown
	task t_back_to_back;
		@(posedge clock);
		instr <= '{or_acc_with_file, 8'h00, 7'h02, 1'b1};
		@(posedge clock);
		instr <= '{move_file_to_dest, 8'h00, 7'h02, 1'b0};
		@(posedge clock);
		instr <= '{op_none, 8'h00, 7'h00, 1'b0};
		#1;
		chk(acc, 8'hFF);
		chk(status, 8'h00);
		chk(file_wr.write, 1'b0);
	endtask

	task t_move;
		run(or_literal_into_acc, 8'h00, 7'h00, 1'b0);
		chk(status, 8'h04);
		run(move_file_to_dest, 8'h00, 7'h7F, 1'b1);
		chk(file_wr, {1'b1, 7'h7F, 8'hFF});
		chk(acc, 8'h00);
		chk(status, 8'h00);
		run(or_literal_into_acc, 8'h00, 7'h00, 1'b0);
		run(move_file_to_dest, 8'h00, 7'h00, 1'b0);
		chk(acc, 8'hFF);
		chk(status, 8'h00);
		chk(file_wr.write, 1'b0);
	endtask

	task give_verdict;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		resetn = 1'b0;
		instr = '{op_none, 8'h00, 7'h00, 1'b0};
		n_errors = 0;
		n_checks = 0;
		do_reset;
		t_literal;
		t_or_file;
		t_idle;
		t_back_to_back;
		do_reset;
		t_move;
		give_verdict;
	end
endmodule
